// *** logic/flash_pkg.sv ***
// shared constants and types for the serial flash bus front end
`default_nettype none
package flash_pkg;
  // address map
  localparam int          ADDR_W         = 24;
  localparam int          SECT_SHIFT     = 12;
  localparam int          BLK32_SHIFT    = 15;
  localparam int          BLK64_SHIFT    = 16;
  localparam int          SECTOR_COUNT   = 2048;
  localparam logic [23:0] ADDR_TOP       = 24'h7fffff;
  localparam logic [7:0]  BLK64_COUNT    = 8'h80;
  // reset values and counts
  localparam logic [7:0]  STATUS_RESET   = 8'h00;
  localparam int          FIFO_DEPTH     = 4;
  localparam logic [2:0]  BIT_LAST_1     = 3'h7;
  localparam logic [2:0]  BIT_LAST_4     = 3'h4;
  localparam logic [1:0]  ADDR_BYTES     = 2'h3;
  // command codes
  localparam logic [7:0]  CMD_WR_EN      = 8'h06;
  localparam logic [7:0]  CMD_WR_DIS     = 8'h04;
  localparam logic [7:0]  CMD_READ_ST    = 8'h05;
  localparam logic [7:0]  CMD_WRITE_ST   = 8'h01;
  localparam logic [7:0]  CMD_PROGRAM    = 8'h02;
  localparam logic [7:0]  CMD_QUAD_ON    = 8'h35;
  localparam logic [7:0]  CMD_QUAD_OFF   = 8'hf5;

  typedef struct packed {
    logic       srwd;
    logic       quad_enable_bit;
    logic [3:0] bp;
    logic       wel;
    logic       write_busy_bit;
  } status_t;

  typedef struct packed {
    logic [10:0] sector;
    logic [7:0]  blk32;
    logic [6:0]  blk64;
    logic        in_range;
  } region_t;

  typedef struct packed {
    logic [23:0] addr;
    logic [7:0]  data;
  } prog_word_t;

  typedef enum logic [1:0] {
    ST_CMD    = 2'b00,
    ST_ADDR   = 2'b01,
    ST_DATA   = 2'b10,
    ST_IGNORE = 2'b11
  } frame_state_t;
endpackage
`default_nettype wire

// *** logic/serial_flash_bus_interface.sv ***
// serial flash bus front end with program data fifo
`timescale 1ns/10ps
`default_nettype none

module prog_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // clock, reset and enable
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             en,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // drain side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  // depth must be a power of two, pointers wrap naturally
  assign in_ready  = count_reg != (AW+1)'(DEPTH);
  assign out_valid = count_reg != '0;
  assign out_data  = mem[rd_ptr_reg];

  always_ff @(posedge clk) begin
    if (en && push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (en) begin
      wr_ptr_reg <= wr_ptr_reg + AW'(push);
      rd_ptr_reg <= rd_ptr_reg + AW'(pop);
      count_reg  <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // prog_fifo

module serial_flash_bus_interface (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic                  clk_en,
  // serial pins
  input  wire logic                  sck,
  input  wire logic                  dev_sel_n,
  input  wire logic                  hw_reset_n,
  input  wire logic [3:0]            quad_line_in,
  output logic [3:0]                 quad_line_out,
  output logic [3:0]                 quad_line_oe_n,
  // array side
  input  wire logic                  array_busy,
  output logic                       prog_valid,
  output flash_pkg::prog_word_t      prog_word,
  input  wire logic                  prog_ready,
  // state
  output flash_pkg::status_t         device_status_byte,
  output logic                       quad_command_mode,
  output flash_pkg::region_t         region
);
  import flash_pkg::*;

  logic [1:0]   sck_sync;
  logic [1:0]   sel_sync;
  logic [1:0]   rstn_sync;
  logic [3:0]   line_meta;
  logic [3:0]   line_s;
  logic         sck_d;
  logic [7:0]   shift_reg;
  logic [2:0]   bit_cnt_reg;
  logic [2:0]   out_idx_reg;
  logic [1:0]   addr_cnt_reg;
  logic [7:0]   cmd_reg;
  logic [23:0]  addr_reg;
  frame_state_t state_reg;
  status_t      status_reg;
  logic         quad_mode_reg;
  logic [3:0]   out_reg;
  logic [3:0]   oe_n_reg;
  region_t      region_reg;
  logic         fifo_ready;
  logic         fifo_valid;

  // pins pass two flops; the second stage is read, and for sck also a third flop (sck_d) for edge detect
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sck_sync  <= 2'h0;
      sel_sync  <= 2'h3;
      rstn_sync <= 2'h3;
      line_meta <= 4'hf;
      line_s    <= 4'hf;
      sck_d     <= 1'b0;
    end else if (clk_en) begin
      sck_sync  <= {sck_sync[0], sck};
      sel_sync  <= {sel_sync[0], dev_sel_n};
      rstn_sync <= {rstn_sync[0], hw_reset_n};
      line_meta <= quad_line_in;
      line_s    <= line_meta;
      sck_d     <= sck_sync[1];
    end
  end

  // edge and frame decode; idle clock level does not matter
  wire       rise      = sck_sync[1] & ~sck_d;
  wire       fall      = ~sck_sync[1] & sck_d;
  wire       selected  = ~sel_sync[1];
  wire       link_rst  = ~rstn_sync[1];
  wire       hold_act  = ~status_reg.quad_enable_bit & ~line_s[3] & selected;
  wire       step      = selected & ~hold_act & ~link_rst;
  wire       frame_end = ~selected | link_rst;
  wire [7:0] in_byte   = quad_mode_reg ? {shift_reg[3:0], line_s}
                                       : {shift_reg[6:0], line_s[0]};
  wire [2:0] bit_last  = quad_mode_reg ? BIT_LAST_4 : BIT_LAST_1;
  wire [2:0] bit_inc   = quad_mode_reg ? 3'h4 : 3'h1;
  wire       bit_rise  = rise & step;
  wire       byte_done = bit_rise & (bit_cnt_reg == bit_last);
  wire       is_cmd    = byte_done & (state_reg == ST_CMD);
  wire       in_data   = byte_done & (state_reg == ST_DATA);
  wire       rd_launch = fall & step & (state_reg == ST_DATA) & (cmd_reg == CMD_READ_ST);

  // protection: top 2^(bp-1) 64 KB blocks, all for bp >= 8
  wire [7:0] prot_low  = (status_reg.bp >= 4'h8) ? 8'h00
                       : BLK64_COUNT - (8'h01 << (status_reg.bp - 4'h1));
  wire       protected_addr = (status_reg.bp != 4'h0) & ({1'b0, addr_reg[22:16]} >= prot_low);
  wire       st_write  = in_data & (cmd_reg == CMD_WRITE_ST);
  wire       prog_push = in_data & (cmd_reg == CMD_PROGRAM) & ~protected_addr & fifo_ready;
  wire       can_write = status_reg.wel & ~status_reg.write_busy_bit;

  // bit collection; shift register keeps its place during pause
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      shift_reg   <= 8'h00;
      bit_cnt_reg <= 3'h0;
    end else if (clk_en) begin
      if (frame_end) begin
        bit_cnt_reg <= 3'h0;
      end else if (bit_rise) begin
        shift_reg   <= in_byte;
        bit_cnt_reg <= byte_done ? 3'h0 : bit_cnt_reg + bit_inc;
      end
    end
  end

  // frame sequencer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg    <= ST_CMD;
      cmd_reg      <= 8'h00;
      addr_reg     <= 24'h000000;
      addr_cnt_reg <= 2'h0;
    end else if (clk_en) begin
      if (frame_end) begin
        state_reg    <= ST_CMD;
        addr_cnt_reg <= 2'h0;
      end else if (is_cmd) begin
        cmd_reg <= in_byte;
        unique case (in_byte)
          CMD_READ_ST:  state_reg <= ST_DATA;
          CMD_WRITE_ST: state_reg <= can_write ? ST_DATA : ST_IGNORE;
          CMD_PROGRAM:  state_reg <= can_write ? ST_ADDR : ST_IGNORE;
          default:      state_reg <= ST_IGNORE;
        endcase
      end else if (byte_done && state_reg == ST_ADDR) begin
        addr_reg     <= {addr_reg[15:0], in_byte};
        addr_cnt_reg <= addr_cnt_reg + 2'h1;
        if (addr_cnt_reg == ADDR_BYTES - 2'h1) begin
          state_reg <= ST_DATA;
        end
      end else if (prog_push) begin
        addr_reg <= addr_reg + 24'h000001;
      end
    end
  end

  // status byte, quad mode; busy bit is set by hardware every cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status_reg    <= status_t'(STATUS_RESET);
      quad_mode_reg <= 1'b0;
    end else if (clk_en) begin
      status_reg.write_busy_bit <= array_busy | fifo_valid;
      if (link_rst) begin
        status_reg.wel <= 1'b0;
        quad_mode_reg  <= 1'b0;
      end else if (st_write) begin
        status_reg.srwd            <= in_byte[7];
        status_reg.quad_enable_bit <= in_byte[6];
        status_reg.bp              <= in_byte[5:2];
        status_reg.wel             <= 1'b0;
        quad_mode_reg              <= quad_mode_reg & in_byte[6];
      end else if (prog_push) begin
        status_reg.wel <= 1'b0;
      end else if (is_cmd) begin
        if (in_byte == CMD_WR_EN) begin
          status_reg.wel <= 1'b1;
        end
        if (in_byte == CMD_WR_DIS) begin
          status_reg.wel <= 1'b0;
        end
        if (in_byte == CMD_QUAD_ON) begin
          quad_mode_reg <= status_reg.quad_enable_bit;
        end
        if (in_byte == CMD_QUAD_OFF) begin
          quad_mode_reg <= 1'b0;
        end
      end
    end
  end

  // output launch; index wraps so the byte repeats until deselect
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      out_reg     <= 4'h0;
      oe_n_reg    <= 4'hf;
      out_idx_reg <= 3'h7;
    end else if (clk_en) begin
      if (frame_end || hold_act) begin
        oe_n_reg <= 4'hf;
        if (frame_end) begin
          out_idx_reg <= 3'h7;
        end
      end else if (rd_launch) begin
        if (quad_mode_reg) begin
          out_reg  <= out_idx_reg[2] ? status_reg[7:4] : status_reg[3:0];
          oe_n_reg <= 4'h0;
        end else begin
          out_reg  <= {2'b00, status_reg[out_idx_reg], 1'b0};
          oe_n_reg <= 4'hd;
        end
        out_idx_reg <= out_idx_reg - bit_inc;
      end
    end
  end

  // sector and block decode of the current address
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      region_reg <= '0;
    end else if (clk_en) begin
      region_reg.sector   <= addr_reg[22:SECT_SHIFT];
      region_reg.blk32    <= addr_reg[22:BLK32_SHIFT];
      region_reg.blk64    <= addr_reg[22:BLK64_SHIFT];
      region_reg.in_range <= addr_reg <= ADDR_TOP;
    end
  end

  // program bytes wait here; a full fifo refuses and keeps busy set
  prog_fifo #(
    .WIDTH ($bits(prog_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (sys_clk),
    .rst       (rst),
    .en        (clk_en),
    .in_valid  (prog_push),
    .in_data   ({addr_reg, in_byte}),
    .in_ready  (fifo_ready),
    .out_valid (fifo_valid),
    .out_data  (prog_word),
    .out_ready (prog_ready)
  );

  assign prog_valid         = fifo_valid;
  assign quad_line_out      = out_reg;
  assign quad_line_oe_n     = oe_n_reg;
  assign device_status_byte = status_reg;
  assign quad_command_mode  = quad_mode_reg;
  assign region             = region_reg;

  AST_SAMPLE_ON_RISE: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && !bit_rise |=> $stable(shift_reg)) else $error("shift moved without rise");
  AST_LAUNCH_ON_FALL: assert property (@(posedge sys_clk) disable iff (rst)
    !$stable(out_reg) |-> $past(fall)) else $error("output changed off a fall");
  AST_PAUSE_FLOATS: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && hold_act |=> quad_line_oe_n == 4'hf) else $error("drive during pause");
  AST_RESET_PIN: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && link_rst |=> quad_line_oe_n == 4'hf && state_reg == ST_CMD)
    else $error("reset pin not honoured");
  AST_SINGLE_LINE_OUT: assert property (@(posedge sys_clk) disable iff (rst)
    !quad_mode_reg && quad_line_oe_n != 4'hf |-> quad_line_oe_n == 4'hd)
    else $error("wrong lines driven");
  AST_QUAD_NEEDS_QE: assert property (@(posedge sys_clk) disable iff (rst)
    quad_mode_reg |-> status_reg.quad_enable_bit) else $error("quad without enable");
  AST_BUSY_BIT: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && array_busy |=> status_reg.write_busy_bit) else $error("busy not shown");
  AST_REPEAT_BYTE: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && rd_launch && !quad_mode_reg && out_idx_reg == 3'h0 && !hold_act
    |=> out_idx_reg == 3'h7) else $error("register byte not repeated");
  AST_MSB_FIRST: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && rd_launch && !quad_mode_reg && out_idx_reg == 3'h7
    |=> quad_line_out[1] == $past(status_reg.srwd)) else $error("msb not first");
  AST_PROTECT: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && in_data && cmd_reg == CMD_PROGRAM && protected_addr |=> $stable(addr_reg))
    else $error("protected byte accepted");
endmodule // serial_flash_bus_interface
`default_nettype wire

// *** testbench/flash_master_model.sv ***
// serial bus master model driving the flash pins
`timescale 1ns/10ps
`default_nettype none
module flash_master_model (
  // serial pins
  output logic            sck,
  output logic            dev_sel_n,
  output logic [3:0]      m_val,
  output logic [3:0]      m_en,
  input  wire logic [3:0] line,
  // received bytes
  output logic            rx_stb,
  output logic [7:0]      rx_byte
);
  // half of the 48 ns link period
  localparam time HALF = 24ns;
  initial begin
    sck = 1'b0;
    dev_sel_n = 1'b1;
    m_val = 4'h0;
    m_en = 4'h0;
    rx_stb = 1'b0;
    rx_byte = 8'h00;
  end
  // one clock: data moves while low, taken on the rise
  task automatic tick(input logic [3:0] v);
    sck = 1'b0;
    m_val = v;
    #HALF;
    sck = 1'b1;
    #HALF;
  endtask
  // clock settles at its idle level before select, so a mode change
  // between frames is never seen as an edge; one select line per memory
  task automatic start(input logic m3);
    sck = m3;
    #HALF;
    dev_sel_n = 1'b0;
    #HALF;
  endtask
  // pause: line 3 held low while selected, clock held still
  task automatic pause(input logic on);
    m_en[3] = on;
    m_val[3] = 1'b0;
  endtask
  // bytes go out high bit first, nibbles high first
  task automatic put(input logic q, input logic [7:0] b);
    m_en = q ? 4'hf : 4'h1;
    if (q) begin
      tick(b[7:4]);
      tick(b[3:0]);
    end else begin
      for (int i = 7; i >= 0; i--) tick({3'h0, b[i]});
    end
  endtask
  // sample late in the high phase: the bit stands until the next fall
  task automatic get(input logic q);
    m_en = 4'h0;
    m_val = ~m_val;
    for (int i = 0; i < (q ? 2 : 8); i++) begin
      sck = 1'b0;
      #HALF;
      sck = 1'b1;
      #HALF;
      rx_byte = q ? {rx_byte[3:0], line} : {rx_byte[6:0], line[1]};
    end
    rx_stb = 1'b1;
    #1;
    rx_stb = 1'b0;
  endtask
  // clock back to idle level, then deselect; clock stays still after
  task automatic stop(input logic m3);
    sck = m3;
    m_en = 4'h0;
    #HALF;
    dev_sel_n = 1'b1;
    #(2 * HALF);
  endtask
endmodule // flash_master_model
`default_nettype wire

// *** testbench/serial_flash_bus_interface_tb_top.sv ***
// self-checking bench for the serial flash bus front end
`timescale 1ns/10ps
`default_nettype none
module serial_flash_bus_interface_tb_top;
  import flash_pkg::*;
  logic        sys_clk, rst, hw_reset_n, prog_ready, hold, prog_valid, qmode, busy;
  logic        sck, dev_sel_n, rx_stb;
  logic [3:0]  line, out, oe_n, m_val, m_en;
  logic [7:0]  rx_byte;
  logic [23:0] a;
  logic [31:0] d;
  logic [31:0] seed = 32'h000165f4;
  prog_word_t  prog_word;
  status_t     st;
  region_t     region;
  int          miscompares = 0;
  int          n_checks = 0;
  logic [7:0]  exp_rx[$];
  logic [31:0] exp_prog[$];
  // all four lines have board pull-ups, so a floating line reads 1
  assign line = (~oe_n & out) | (oe_n & m_en & m_val) | (oe_n & ~m_en);
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  serial_flash_bus_interface dut_u (
    .sys_clk(sys_clk), .rst(rst), .clk_en(1'b1), .sck(sck), .dev_sel_n(dev_sel_n),
    .hw_reset_n(hw_reset_n), .quad_line_in(line), .quad_line_out(out),
    .quad_line_oe_n(oe_n), .array_busy(busy), .prog_valid(prog_valid),
    .prog_word(prog_word), .prog_ready(prog_ready), .device_status_byte(st),
    .quad_command_mode(qmode), .region(region));
  flash_master_model m_u (
    .sck(sck), .dev_sel_n(dev_sel_n), .m_val(m_val), .m_en(m_en), .line(line),
    .rx_stb(rx_stb), .rx_byte(rx_byte));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic summarize();
    if (miscompares == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // consumer stalls at random, or fully while hold is set
  always @(posedge sys_clk) begin
    seed <= xs(seed);
    prog_ready <= #1 ~hold & seed[0];
  end
  // watchers take the oldest expectation when a result shows
  always @(posedge sys_clk)
    if (prog_valid === 1'b1 && prog_ready) check(prog_word, exp_prog.pop_front());
  always @(posedge rx_stb) check({24'h0, rx_byte}, {24'h0, exp_rx.pop_front()});
  // one select window: n bytes sent, then nrd bytes read back
  task automatic frame(input logic m3, input logic q, input int n, input logic [71:0] b,
                       input int nrd, input logic [7:0] want);
    m_u.start(m3);
    for (int i = 0; i < n; i++) m_u.put(q, b[71-8*i -: 8]);
    for (int i = 0; i < nrd; i++) begin
      exp_rx.push_back(want);
      m_u.get(q);
    end
    m_u.stop(m3);
  endtask
  initial begin
    rst = 1'b1;
    hw_reset_n = 1'b1;
    hold = 1'b1;
    busy = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge sys_clk);
    check(st, STATUS_RESET);
    check(oe_n, 4'hf);
    check(qmode, 1'b0);
    frame(1'b0, 1'b0, 1, {CMD_READ_ST, 64'h0}, 2, 8'h00);
    frame(1'b1, 1'b0, 1, {CMD_WR_EN, 64'h0}, 0, 8'h00);
    frame(1'b1, 1'b0, 1, {CMD_READ_ST, 64'h0}, 1, 8'h02);
    // fill the fifo while stalled; the fifth byte finds no room
    a = seed[23:0] & 24'h7ff0f0;
    d = xs(seed);
    for (int i = 0; i < 4; i++) exp_prog.push_back({a + 24'(i), d[31-8*i -: 8]});
    frame(1'b0, 1'b0, 1, {CMD_WR_EN, 64'h0}, 0, 8'h00);
    frame(1'b0, 1'b0, 9, {CMD_PROGRAM, a, d, 8'h5a}, 0, 8'h00);
    frame(1'b0, 1'b0, 1, {CMD_READ_ST, 64'h0}, 1, 8'h01);
    check(region, {a[22:12], a[22:15], a[22:16], 1'b1});
    hold = 1'b0;
    for (int i = 0; i < 400 && prog_valid !== 1'b0; i++) @(posedge sys_clk);
    check(exp_prog.size(), 0);
    frame(1'b0, 1'b0, 1, {CMD_READ_ST, 64'h0}, 1, 8'h00);
    // array busy alone shows in bit 0
    @(posedge sys_clk);
    #1 busy = 1'b1;
    frame(1'b0, 1'b0, 1, {CMD_READ_ST, 64'h0}, 1, 8'h01);
    @(posedge sys_clk);
    #1 busy = 1'b0;
    // pause mid-read floats the output; the byte then resumes from bit 7
    m_u.start(1'b0);
    m_u.put(1'b0, CMD_READ_ST);
    exp_rx.push_back(8'h00);
    m_u.get(1'b0);
    check(oe_n, 4'hd);
    m_u.pause(1'b1);
    repeat (6) @(posedge sys_clk);
    check(oe_n, 4'hf);
    m_u.pause(1'b0);
    repeat (3) @(posedge sys_clk);
    exp_rx.push_back(8'h00);
    m_u.get(1'b0);
    m_u.stop(1'b0);
    // every block protected: the program byte is dropped, wel stays set
    frame(1'b0, 1'b0, 1, {CMD_WR_EN, 64'h0}, 0, 8'h00);
    frame(1'b0, 1'b0, 2, {CMD_WRITE_ST, 8'h20, 56'h0}, 0, 8'h00);
    frame(1'b0, 1'b0, 1, {CMD_WR_EN, 64'h0}, 0, 8'h00);
    frame(1'b0, 1'b0, 5, {CMD_PROGRAM, a, 8'hc3, 32'h0}, 0, 8'h00);
    check(prog_valid, 1'b0);
    frame(1'b0, 1'b0, 1, {CMD_READ_ST, 64'h0}, 1, 8'h22);
    // quad mode after setting the enable bit
    frame(1'b0, 1'b0, 1, {CMD_WR_EN, 64'h0}, 0, 8'h00);
    frame(1'b0, 1'b0, 2, {CMD_WRITE_ST, 8'h40, 56'h0}, 0, 8'h00);
    frame(1'b1, 1'b0, 1, {CMD_QUAD_ON, 64'h0}, 0, 8'h00);
    check(qmode, 1'b1);
    frame(1'b1, 1'b1, 1, {CMD_READ_ST, 64'h0}, 2, 8'h40);
    // pin reset drops quad mode and floats, stored bits stay
    @(posedge sys_clk);
    #1 hw_reset_n = 1'b0;
    repeat (6) @(posedge sys_clk);
    check(oe_n, 4'hf);
    check(qmode, 1'b0);
    check(st, 8'h40);
    #1 hw_reset_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    frame(1'b0, 1'b0, 1, {CMD_READ_ST, 64'h0}, 1, 8'h40);
    summarize();
  end
  // watchdog: the run needs some 19 us
  initial begin
    #100us;
    miscompares++;
    summarize();
  end
endmodule // serial_flash_bus_interface_tb_top
`default_nettype wire
